// >>> can_ctrl_model.sv
`timescale 1ns/10ps
module can_ctrl_model #(
   parameter int BIT_CYC = 2
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // Commands
   input  wire logic [7:0] tx_word,
   input  wire logic       send,
   input  wire logic       stuck,
   // Pins
   output logic            txd_pin,
   output logic            busy
);
   logic [7:0] sh_ff;
   logic [3:0] nbit_ff;
   int         cnt_ff;

   assign busy = (nbit_ff != 4'h0);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sh_ff   <= 8'h00;
         nbit_ff <= 4'h0;
         cnt_ff  <= 0;
         txd_pin <= 1'b1;
      end else if (stuck) begin
         txd_pin <= 1'b0;
      end else if (send && !busy) begin
         sh_ff   <= tx_word;
         nbit_ff <= 4'h8;
         cnt_ff  <= BIT_CYC - 1;
         txd_pin <= tx_word[7];
      end else if (busy && cnt_ff == 0) begin
         // Eight bits at most, well under the time-out
         nbit_ff <= nbit_ff - 4'h1;
         cnt_ff  <= BIT_CYC - 1;
         sh_ff   <= sh_ff << 1;
         txd_pin <= (nbit_ff == 4'h1) ? 1'b1 : sh_ff[6];
      end else if (busy) begin
         cnt_ff <= cnt_ff - 1;
      end else begin
         txd_pin <= 1'b1;
      end
   end
endmodule : can_ctrl_model

// >>> can_failsafe_pkg.sv
// Functional notes
// - Enable high, silent low: Normal; drive dominant on transmit low, else recessive.
// - Enable high, silent high: transmitter off, bus recessive, receiver keeps working.
// - Enable low: Off mode; bus outputs and receive output float, inputs ignored.
// - Normal and Silent: receive output low on dominant bus, high on recessive.
// - Transmit low starts timer; too long a low disables transmitter, bus recessive.
// - Transmit high clears the timer and re-enables transmission.
// - Floating transmit reads high; floating silent and enable read low.
// - Either undervoltage flag switches device off, zero load, until both recover.
// - Overtemperature disables drivers until flag clears and transmit is high again.
package can_failsafe_pkg;

   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_NORMAL,
      MODE_SILENT,
      MODE_UNDERVOLT
   } mode_t;

   // Clock and timing
   localparam int  CLK_HZ             = 10_000_000;
   localparam int  US_PER_S           = 1_000_000;
   localparam int  DOM_TIMEOUT_US     = 1000;
   localparam int  DOM_TIMEOUT_CYC    = DOM_TIMEOUT_US * (CLK_HZ / US_PER_S);
   localparam int  MIN_BIT_RATE_BPS   = 20_000;

   // Register byte addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_EVENT  = 4'h8;
   localparam logic [3:0] ADDR_TCOUNT = 4'hC;

   // Control fields
   localparam int  CTRL_TOUT_EN_BIT   = 0;
   localparam int  CTRL_FORCE_SIL_BIT = 1;
   localparam logic CTRL_TOUT_EN_RST  = 1'b1;
   localparam logic CTRL_FORCE_SIL_RST = 1'b0;

   // Status fields
   localparam int  ST_MODE_LSB        = 0;
   localparam int  ST_TOUT_LOCK_BIT   = 2;
   localparam int  ST_THERM_LOCK_BIT  = 3;
   localparam int  ST_TXD_BIT         = 4;
   localparam int  ST_BUS_DOM_BIT     = 5;

   // Event word
   localparam int  EVT_NUM            = 4;
   localparam int  EVT_CODE_W         = 2;
   localparam int  EVT_VALID_BIT      = 8;
   localparam logic [1:0] EVT_TOUT    = 2'h0;
   localparam logic [1:0] EVT_THERM   = 2'h1;
   localparam logic [1:0] EVT_UV      = 2'h2;
   localparam logic [1:0] EVT_MODE    = 2'h3;

   // Synchroniser reset levels: txd, silent, enable, bus, uv_vcc, uv_vio, ot
   localparam int  SYNC_W             = 7;
   localparam logic [6:0] SYNC_INIT  = 7'h01;

endpackage : can_failsafe_pkg

// >>> can_mode_failsafe.sv
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module can_mode_failsafe
   import can_failsafe_pkg::*;
#(
   parameter int dominant_timeout_period = DOM_TIMEOUT_CYC,
   parameter int EVT_DEPTH               = 2
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Controller side pins
   input  wire logic        txd_pin,
   input  wire logic        silent_pin,
   input  wire logic        enable_pin,
   output logic             rxd_out,
   output logic             rxd_oe,
   // Line side
   input  wire logic        bus_dom_pin,
   output logic             can_drive_dom,
   output logic             can_bias_en,
   // Supply and thermal flags
   input  wire logic        uv_vcc_pin,
   input  wire logic        uv_vio_pin,
   input  wire logic        overtemp_pin,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o
);

   localparam int TW = $clog2(dominant_timeout_period + 1);

   // Synchronised pins
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic              txd_s;
   logic              silent_s;
   logic              enable_s;
   logic              bus_dom_s;
   logic              uv_vcc_s;
   logic              uv_vio_s;
   logic              ot_s;

   // Control registers
   logic              tout_en_ff;
   logic              force_sil_ff;

   // Protection state
   logic [TW-1:0]     tcount_ff;
   logic              tout_lock_ff;
   logic              therm_lock_ff;
   logic              undervolt;
   mode_t             mode;
   mode_t             mode_ff;

   // Next values of the output registers
   logic              nxt_drive_dom;
   logic              nxt_bias_en;
   logic              nxt_rxd;
   logic              nxt_rxd_oe;

   // Events
   logic [EVT_NUM-1:0]    evt_set;
   logic [EVT_NUM-1:0]    evt_pend_ff;
   logic [EVT_NUM-1:0]    evt_pick;
   logic [EVT_CODE_W-1:0] evt_code;
   logic                  evt_in_ready;
   logic                  evt_out_valid;
   logic [EVT_CODE_W-1:0] evt_out_data;
   logic                  evt_pop;
   logic                  tout_lock_d_ff;
   logic                  therm_lock_d_ff;
   logic                  uv_d_ff;

   // Bus access
   logic              access;
   logic              wr_access;
   logic              rd_access;
   logic [31:0]       nxt_rdata;

   // Pin synchronisation; reset levels give the safe Off state with bias disabled
   assign pins_raw = {overtemp_pin, uv_vio_pin, uv_vcc_pin, bus_dom_pin,
                      enable_pin, silent_pin, txd_pin};

   sync2 #(
      .W    (SYNC_W),
      .INIT (SYNC_INIT)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   assign txd_s     = pins_s[0];
   assign silent_s  = pins_s[1];
   assign enable_s  = pins_s[2];
   assign bus_dom_s = pins_s[3];
   assign uv_vcc_s  = pins_s[4];
   assign uv_vio_s  = pins_s[5];
   assign ot_s      = pins_s[6];

   // Either supply low switches the device off
   assign undervolt = uv_vcc_s || uv_vio_s;

   // Mode decode
   always_comb begin
      if (undervolt) begin
         mode = MODE_UNDERVOLT;
      end else if (!enable_s) begin
         mode = MODE_OFF;
      end else if (silent_s || force_sil_ff) begin
         mode = MODE_SILENT;
      end else begin
         mode = MODE_NORMAL;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= MODE_OFF;
      end else begin
         mode_ff <= mode;
      end
   end

   // Dominant time-out counter
   // Counts every cycle of a low transmit level; saturates at the period.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tcount_ff <= '0;
      end else if (txd_s) begin
         tcount_ff <= '0;
      end else if (tcount_ff != TW'(dominant_timeout_period)) begin
         tcount_ff <= tcount_ff + TW'(1);
      end
   end

   // Lock once the low level outlasts the period; released by a high level
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tout_lock_ff <= 1'b0;
      end else if (txd_s) begin
         tout_lock_ff <= 1'b0;
      end else if (tout_en_ff &&
                   tcount_ff == TW'(dominant_timeout_period)) begin
         tout_lock_ff <= 1'b1;
      end
   end

   // Thermal lock: set wins; clear needs cool die and recessive transmit
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         therm_lock_ff <= 1'b0;
      end else if (ot_s) begin
         therm_lock_ff <= 1'b1;
      end else if (txd_s) begin
         therm_lock_ff <= 1'b0;
      end
   end

   // Line and receive output decisions
   always_comb begin
      nxt_drive_dom = 1'b0;
      nxt_bias_en   = 1'b0;
      nxt_rxd       = 1'b1;
      nxt_rxd_oe    = 1'b0;
      case (mode)
         MODE_NORMAL: begin
            nxt_bias_en   = 1'b1;
            nxt_drive_dom = !txd_s && !tout_lock_ff
                            && !therm_lock_ff;
            nxt_rxd       = !bus_dom_s;
            nxt_rxd_oe    = 1'b1;
         end
         MODE_SILENT: begin
            nxt_bias_en   = 1'b1;
            nxt_drive_dom = 1'b0;
            nxt_rxd       = !bus_dom_s;
            nxt_rxd_oe    = 1'b1;
         end
         MODE_OFF: begin
            nxt_bias_en   = 1'b0;
            nxt_rxd_oe    = 1'b0;
         end
         MODE_UNDERVOLT: begin
            nxt_bias_en   = 1'b0;
            nxt_rxd_oe    = 1'b0;
         end
         default: begin
            nxt_bias_en   = 1'b0;
            nxt_rxd_oe    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         can_drive_dom <= 1'b0;
         can_bias_en   <= 1'b0;
         rxd_out       <= 1'b1;
         rxd_oe        <= 1'b0;
      end else begin
         can_drive_dom <= nxt_drive_dom;
         can_bias_en   <= nxt_bias_en;
         rxd_out       <= nxt_rxd;
         rxd_oe        <= nxt_rxd_oe;
      end
   end

   // Event detection: rising edges of the locks, undervoltage and mode change
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tout_lock_d_ff  <= 1'b0;
         therm_lock_d_ff <= 1'b0;
         uv_d_ff         <= 1'b0;
      end else begin
         tout_lock_d_ff  <= tout_lock_ff;
         therm_lock_d_ff <= therm_lock_ff;
         uv_d_ff         <= undervolt;
      end
   end

   always_comb begin
      evt_set            = '0;
      evt_set[EVT_TOUT]  = tout_lock_ff && !tout_lock_d_ff;
      evt_set[EVT_THERM] = therm_lock_ff && !therm_lock_d_ff;
      evt_set[EVT_UV]    = undervolt && !uv_d_ff;
      evt_set[EVT_MODE]  = (mode != mode_ff);
   end

   function automatic logic [EVT_NUM-1:0] lowest(input logic [EVT_NUM-1:0] v);
      lowest = v & (~v + EVT_NUM'(1));
   endfunction : lowest

   function automatic logic [EVT_CODE_W-1:0] encode(input logic [EVT_NUM-1:0] v);
      encode = '0;
      for (int i = 0; i < EVT_NUM; i++) begin
         if (v[i]) begin
            encode = EVT_CODE_W'(i);
         end
      end
   endfunction : encode

   assign evt_pick = lowest(evt_pend_ff);
   assign evt_code = encode(evt_pick);

   // Pending flags wait for buffer room; a new event beats its own clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         evt_pend_ff <= '0;
      end else begin
         evt_pend_ff <= (evt_pend_ff & ~(evt_in_ready ? evt_pick : '0))
                        | evt_set;
      end
   end

   evt_buffer #(
      .W     (EVT_CODE_W),
      .DEPTH (EVT_DEPTH)
   ) u_evt (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (evt_pend_ff != '0),
      .in_ready  (evt_in_ready),
      .in_data   (evt_code),
      .out_valid (evt_out_valid),
      .out_ready (evt_pop),
      .out_data  (evt_out_data)
   );

   // Wishbone classic slave: answer one cycle after the request
   assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_access = access && wb_we_i;
   assign rd_access = access && !wb_we_i;
   assign evt_pop   = rd_access && (wb_adr_i == ADDR_EVENT);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tout_en_ff   <= CTRL_TOUT_EN_RST;
         force_sil_ff <= CTRL_FORCE_SIL_RST;
      end else if (wr_access && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
         tout_en_ff   <= wb_dat_i[CTRL_TOUT_EN_BIT];
         force_sil_ff <= wb_dat_i[CTRL_FORCE_SIL_BIT];
      end
   end

   always_comb begin
      nxt_rdata = '0;
      case (wb_adr_i)
         ADDR_CTRL: begin
            nxt_rdata[CTRL_TOUT_EN_BIT]   = tout_en_ff;
            nxt_rdata[CTRL_FORCE_SIL_BIT] = force_sil_ff;
         end
         ADDR_STATUS: begin
            nxt_rdata[ST_MODE_LSB +: 2]   = mode_ff;
            nxt_rdata[ST_TOUT_LOCK_BIT]   = tout_lock_ff;
            nxt_rdata[ST_THERM_LOCK_BIT]  = therm_lock_ff;
            nxt_rdata[ST_TXD_BIT]         = txd_s;
            nxt_rdata[ST_BUS_DOM_BIT]     = bus_dom_s;
         end
         ADDR_EVENT: begin
            nxt_rdata[EVT_CODE_W-1:0]     = evt_out_data;
            nxt_rdata[EVT_VALID_BIT]      = evt_out_valid;
         end
         ADDR_TCOUNT: begin
            nxt_rdata[TW-1:0]             = tcount_ff;
         end
         default: begin
            nxt_rdata = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= '0;
      end else if (rd_access) begin
         wb_dat_o <= nxt_rdata;
      end
   end

endmodule : can_mode_failsafe

// >>> can_mode_failsafe_properties.sv
`timescale 1ns/10ps
module can_mode_failsafe_properties
   import can_failsafe_pkg::*;
#(
   parameter int dominant_timeout_period = DOM_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset_n,
   // Pins
   input wire logic        txd_pin,
   input wire logic        silent_pin,
   input wire logic        enable_pin,
   input wire logic        rxd_out,
   input wire logic        rxd_oe,
   input wire logic        bus_dom_pin,
   input wire logic        can_drive_dom,
   input wire logic        can_bias_en,
   input wire logic        uv_vcc_pin,
   input wire logic        uv_vio_pin,
   input wire logic        overtemp_pin,
   // Wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o
);
   logic [15:0] low_cnt_ff;
   wire         norm = enable_pin && !silent_pin && !uv_vcc_pin && !uv_vio_pin && !overtemp_pin;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Length of the current low run on the transmit pin
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_ff <= 16'h0000;
      end else if (txd_pin) begin
         low_cnt_ff <= 16'h0000;
      end else if (low_cnt_ff != 16'hFFFF) begin
         low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
   end

   sequence s_idle_hi; (norm && txd_pin)[*3]; endsequence
   sequence s_low;     (norm && !txd_pin)[*3]; endsequence

   property p_drv; can_drive_dom |-> $past(enable_pin && !silent_pin && !txd_pin, 3); endproperty
   property p_silent; (enable_pin && silent_pin)[*3] |=> !can_drive_dom; endproperty
   property p_off; (!enable_pin)[*3] |=> !can_bias_en && !rxd_oe && !can_drive_dom; endproperty
   property p_rxd; rxd_oe |-> rxd_out == !$past(bus_dom_pin, 3); endproperty
   property p_tout; int'(low_cnt_ff) > dominant_timeout_period + 6 |-> !can_drive_dom; endproperty
   property p_resume; s_idle_hi ##1 s_low |=> can_drive_dom; endproperty
   property p_uv; (uv_vcc_pin || uv_vio_pin)[*3] |=> !can_bias_en && !rxd_oe; endproperty
   property p_therm;
      (overtemp_pin && !txd_pin)[*3] ##1 (!overtemp_pin && !txd_pin)[*5] |=> !can_drive_dom;
   endproperty
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty

   a_drv: assert property (p_drv) else $error("dominant drive without cause");
   a_silent: assert property (p_silent) else $error("drive in silent mode");
   a_off: assert property (p_off) else $error("outputs active in off mode");
   a_rxd: assert property (p_rxd) else $error("receive output wrong level");
   a_tout: assert property (p_tout) else $error("dominant past time-out");
   a_resume: assert property (p_resume) else $error("drive not resumed");
   a_uv: assert property (p_uv) else $error("active during undervoltage");
   a_therm: assert property (p_therm) else $error("drive back before txd high");
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
endmodule : can_mode_failsafe_properties

bind can_mode_failsafe can_mode_failsafe_properties #(
   .dominant_timeout_period(dominant_timeout_period)
) props_inst (
   .clk_sys, .reset_n, .txd_pin, .silent_pin, .enable_pin, .rxd_out, .rxd_oe,
   .bus_dom_pin, .can_drive_dom, .can_bias_en, .uv_vcc_pin, .uv_vio_pin, .overtemp_pin,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
);

// >>> evt_buffer.sv
`timescale 1ns/10ps
module evt_buffer #(
   parameter int W     = 2,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_ff [DEPTH];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [CW-1:0] cnt_ff;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_ff != CW'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem_ff[rd_ff];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : bump

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= bump(wr_ff);
         end
         if (pop) begin
            rd_ff <= bump(rd_ff);
         end
         cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
      end
   end

endmodule : evt_buffer

// >>> sync2.sv
`timescale 1ns/10ps
module sync2 #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_ff;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff  <= INIT;
         sync_out <= INIT;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule : sync2

// >>> tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) miss(nm, 32'(e), 32'(g)); end
module tb
   import can_failsafe_pkg::*;
;
   localparam int P = 20;
   logic        clk_sys, reset_n, txd_pin, silent_pin, enable_pin, bus_other, busy;
   logic        uv_vcc_pin, uv_vio_pin, overtemp_pin, send, stuck;
   logic        rxd_out, rxd_oe, can_drive_dom, can_bias_en;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd_last;
   logic [7:0]  tx_word;
   logic [31:0] exp_q[$], msk_q[$];
   wire         bus_dom_pin = can_drive_dom | bus_other;
   int          n_errors = 0, tests_run = 0, seed = 3448, npop;

   always #50 clk_sys = ~clk_sys;

   can_mode_failsafe #(.dominant_timeout_period(P)) can_mode_failsafe_inst (
      .clk_sys, .reset_n, .txd_pin, .silent_pin, .enable_pin, .rxd_out, .rxd_oe,
      .bus_dom_pin, .can_drive_dom, .can_bias_en, .uv_vcc_pin, .uv_vio_pin, .overtemp_pin,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   can_ctrl_model #(.BIT_CYC(2)) can_ctrl_model_inst (
      .clk_sys, .reset_n, .tx_word, .send, .stuck, .txd_pin, .busy);

   task automatic miss(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
   endtask : miss

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt

   task automatic pins(input logic d, input logic b, input logic o, input logic r);
      @(posedge clk_sys);
      `CHK("can_drive_dom", d, can_drive_dom)
      `CHK("can_bias_en", b, can_bias_en)
      `CHK("rxd_oe", o, rxd_oe)
      `CHK("rxd_out", r, rxd_out)
   endtask : pins

   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
      int i;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      if (!we) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         print_verdict;
      end
      rd_last = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      wb(1'b0, a, 32'h0, e, m);
   endtask : rd

   task automatic drain(output int n);
      n = 0;
      for (int i = 0; i < 8; i++) begin
         rd(ADDR_EVENT, 32'h0, 32'h0);
         if (rd_last[EVT_VALID_BIT] !== 1'b1) break;
         n++;
      end
   endtask : drain

   // Read checker: oldest note against returned data
   always @(posedge clk_sys) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         if (msk_q[0] != 32'h0) `CHK("read data", exp_q[0] & msk_q[0], wb_dat_o & msk_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      n_errors++;
      print_verdict;
   end

   initial begin
      clk_sys = 0; reset_n = 0; enable_pin = 0; silent_pin = 0; bus_other = 0;
      uv_vcc_pin = 0; uv_vio_pin = 0; overtemp_pin = 0; send = 0; stuck = 0; tx_word = 0;
      wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 0; wb_dat_i = 0;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      pins(0, 0, 0, 1);
      rd(ADDR_CTRL, 32'h1, 32'h3);
      rd(4'h2, 32'h0, 32'hFFFFFFFF);
      wb(1'b1, ADDR_STATUS, 32'hFF, 32'h0, 32'h0);
      rd(ADDR_STATUS, 32'(MODE_OFF), 32'hF);
      enable_pin <= 1'b1;
      wt(4);
      rd(ADDR_STATUS, 32'(MODE_NORMAL), 32'hF);
      stuck <= 1'b1; wt(7); pins(1, 1, 1, 0);
      stuck <= 1'b0; wt(7); pins(0, 1, 1, 1);
      for (int k = 0; k < 6; k++) begin
         tx_word <= 8'($random(seed));
         bus_other <= 1'($random(seed));
         send <= 1'b1;
         wt(1);
         send <= 1'b0;
         wt(1);
         for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_sys);
         if (busy !== 1'b0) begin
            n_errors++;
            print_verdict;
         end
      end
      bus_other <= 1'b0;
      silent_pin <= 1'b1; stuck <= 1'b1; wt(4); pins(0, 1, 1, 1);
      bus_other <= 1'b1; wt(4); pins(0, 1, 1, 0);
      rd(ADDR_STATUS, 32'(MODE_SILENT), 32'h3);
      silent_pin <= 1'b0; bus_other <= 1'b0; stuck <= 1'b0; wt(4);
      drain(npop);
      rd(ADDR_EVENT, 32'h0, 32'h100);
      stuck <= 1'b1; wt(P + 10); pins(0, 1, 1, 1);
      rd(ADDR_STATUS, 32'h4 | 32'(MODE_NORMAL), 32'h7);
      rd(ADDR_TCOUNT, 32'(P), 32'hFFFF);
      rd(ADDR_EVENT, 32'h100 | 32'(EVT_TOUT), 32'h103);
      stuck <= 1'b0; wt(4);
      rd(ADDR_STATUS, 32'(MODE_NORMAL), 32'h7);
      stuck <= 1'b1; wt(7); pins(1, 1, 1, 0);
      stuck <= 1'b0; wt(4);
      stuck <= 1'b1; overtemp_pin <= 1'b1; wt(4); pins(0, 1, 1, 1);
      overtemp_pin <= 1'b0; wt(4); pins(0, 1, 1, 1);
      rd(ADDR_STATUS, 32'h8 | 32'(MODE_NORMAL), 32'hF);
      stuck <= 1'b0; wt(4);
      stuck <= 1'b1; wt(7); pins(1, 1, 1, 0);
      stuck <= 1'b0;
      for (int i = 1; i < 4; i++) begin
         {uv_vcc_pin, uv_vio_pin} <= 2'(i); wt(4); pins(0, 0, 0, 1);
         rd(ADDR_STATUS, 32'(MODE_UNDERVOLT), 32'h3);
      end
      uv_vio_pin <= 1'b0; wt(4); pins(0, 0, 0, 1);
      uv_vcc_pin <= 1'b0; wt(4); pins(0, 1, 1, 1);
      drain(npop);
      // Thermal and undervoltage fill the buffer; mode change waits, coalesced
      `CHK("events drained", 3, npop)
      rd(ADDR_EVENT, 32'h0, 32'h100);
      wb(1'b1, ADDR_CTRL, 32'h3, 32'h0, 32'h0);
      rd(ADDR_CTRL, 32'h3, 32'h3);
      rd(ADDR_STATUS, 32'(MODE_SILENT), 32'h3);
      bus_other <= 1'b1; wt(4); pins(0, 1, 1, 0);
      bus_other <= 1'b0;
      enable_pin <= 1'b0; stuck <= 1'b1; wt(4); pins(0, 0, 0, 1);
      rd(ADDR_STATUS, 32'(MODE_OFF), 32'h3);
      print_verdict;
   end
endmodule : tb
